// ---- rtl/apr_pkg.sv ----
package apr_pkg;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [7:0]  ADDR_ROUTE1   = 8'h24;
  localparam logic [7:0]  ADDR_ROUTE2   = 8'h28;
  localparam logic [7:0]  ADDR_PINCFG   = 8'h2C;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h34;
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'h38;
  localparam logic [7:0]  ADDR_PIN_STAT = 8'h3C;

  // routing register layout, same for both pins
  localparam int          ROUTE_W       = 24;
  localparam logic [23:0] ROUTE_RST     = 24'h00_0000;
  localparam logic [23:0] ROUTE_MASK    = 24'hFF_FFFE;
  localparam int          OC_MSB        = 23;
  localparam int          UC_MSB        = 19;
  localparam int          OV_MSB        = 15;
  localparam int          UV_MSB        = 11;
  localparam int          OP_MSB        = 7;
  localparam int          ACCV_BIT      = 3;
  localparam int          ACCC_BIT      = 2;
  localparam int          CC_BIT        = 1;
  localparam int          UNIMP_BIT     = 0;
  localparam int          NUM_CH        = 4;

  // pin function bits: set means the pin works as alert output
  localparam int          NUM_PINS      = 2;
  localparam logic [1:0]  PINCFG_RST    = 2'h0;

  // interrupt event bits
  localparam int          IRQ_W         = 3;
  localparam int          EV_PIN1       = 0;
  localparam int          EV_PIN2       = 1;
  localparam int          EV_SLOW       = 2;
  localparam logic [2:0]  IRQ_RST       = 3'h0;

  // pin status read-back bits
  localparam int          PS_SLOW       = 2;
  localparam int          PS_PULSE1     = 3;
  localparam int          PS_PULSE2     = 4;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // conversion-complete pulse timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          CC_PULSE_NS   = 5000;
  localparam int          CC_PULSE_CYC  = (CC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- rtl/apr_pulse.sv ----
`timescale 1ns/1ps
module apr_pulse #(
  parameter int unsigned CYCLES = apr_pkg::CC_PULSE_CYC,
  parameter int unsigned CW     = 8
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output logic      active_r
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] since_r;

  // a new start restarts the full width, so back-to-back ends never merge short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= '0;
      active_r <= 1'b0;
    end else if (start) begin
      cnt_r    <= CW'(CYCLES - 1);
      active_r <= 1'b1;
    end else if (active_r) begin
      if (cnt_r == '0) begin
        active_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // checker helper: edges since the last start, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_r <= '0;
    end else if (start) begin
      since_r <= CW'(1);
    end else if (since_r != '1) begin
      since_r <= since_r + 1'b1;
    end
  end

  pulse_start_a: assert property (
    @(posedge aclk) disable iff (!aresetn) start |=> active_r)
    else $error("pulse did not start after trigger");

  pulse_width_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(active_r) |-> since_r == CW'(CYCLES + 1))
    else $error("pulse width differs from five microseconds");

  pulse_bound_a: assert property (
    @(posedge aclk) disable iff (!aresetn) active_r |-> since_r <= CW'(CYCLES))
    else $error("pulse outlasted its width");

endmodule // apr_pulse

// ---- rtl/apr_top.sv ----
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module apr_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  ch_overcurrent,
  input  wire logic [3:0]  ch_undercurrent,
  input  wire logic [3:0]  ch_overvoltage,
  input  wire logic [3:0]  ch_undervoltage,
  input  wire logic [3:0]  ch_overpower,
  input  wire logic        accum_value_full,
  input  wire logic        accum_count_full,
  input  wire logic        conv_cycle_end,
  input  wire logic        first_alert_pin_i,
  output logic             first_alert_pin_o,
  output logic             first_alert_pin_oe,
  output logic             second_alert_pin_o,
  output logic             second_alert_pin_oe,
  output logic             slow_sample_req,
  output logic             irq
);

  localparam int RW = apr_pkg::ROUTE_W;
  localparam int NP = apr_pkg::NUM_PINS;

  logic                     awready_r;
  logic                     wready_r;
  logic                     bvalid_r;
  logic [1:0]               bresp_r;
  logic                     arready_r;
  logic                     rvalid_r;
  logic [1:0]               rresp_r;
  logic [31:0]              rdata_r;
  logic [7:0]               aw_addr_r;
  logic [31:0]              w_data_r;
  logic [3:0]               w_strb_r;
  logic                     wr_fire;
  logic [RW-1:0]            route_r [NP];
  logic [RW-1:0]            route_mrg [NP];
  logic [NP-1:0]            pincfg_r;
  logic [apr_pkg::IRQ_W-1:0] irq_stat_r;
  logic [apr_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [apr_pkg::IRQ_W-1:0] irq_en_r;
  logic [apr_pkg::IRQ_W-1:0] irq_ev;
  logic [apr_pkg::IRQ_W-1:0] irq_clr;
  logic                     irq_r;
  logic [RW-1:0]            src_vec;
  logic [NP-1:0]            pulse_start;
  logic [NP-1:0]            pulse_act;
  logic [NP-1:0]            level_nxt;
  logic [NP-1:0]            pin_o_r;
  logic [NP-1:0]            pin_oe_r;
  logic                     slow_s1_r;
  logic                     slow_s2_r;
  logic                     slow_s3_r;
  logic                     slow_r;
  logic                     slow_req_nxt;
  logic                     slow_req_r;
  logic [31:0]              rd_data_c;
  logic                     rd_err_c;
  logic                     wr_err_c;
  logic [RW-1:0]            wd_route;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ports straight from their flops
  assign awready             = awready_r;
  assign wready              = wready_r;
  assign bvalid              = bvalid_r;
  assign bresp               = bresp_r;
  assign arready             = arready_r;
  assign rvalid              = rvalid_r;
  assign rresp               = rresp_r;
  assign rdata               = rdata_r;
  assign first_alert_pin_o   = pin_o_r[0];
  assign first_alert_pin_oe  = pin_oe_r[0];
  assign second_alert_pin_o  = pin_o_r[1];
  assign second_alert_pin_oe = pin_oe_r[1];
  assign slow_sample_req     = slow_req_r;
  assign irq                 = irq_r;

  // write side: address and data are held independently, write once both are in
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= apr_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_err_c ? apr_pkg::RESP_SLVERR : apr_pkg::RESP_OKAY;
      end
      // channels reopen only after the response is taken: one write in flight
      if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read-only and unmapped words refuse writes with an error response
  always_comb begin
    case (aw_addr_r)
      apr_pkg::ADDR_ROUTE1, apr_pkg::ADDR_ROUTE2, apr_pkg::ADDR_PINCFG,
      apr_pkg::ADDR_IRQ_CLR, apr_pkg::ADDR_IRQ_EN: wr_err_c = 1'b0;
      default:                                     wr_err_c = 1'b1;
    endcase
  end

  // byte-lane merge of routing words; the unimplemented bit is forced low
  always_comb begin
    for (int k = 0; k < NP; k++) begin
      route_mrg[k] = RW'(merge_bytes({8'h00, route_r[k]}, w_data_r, w_strb_r))
                     & apr_pkg::ROUTE_MASK;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_r[0] <= apr_pkg::ROUTE_RST;
      route_r[1] <= apr_pkg::ROUTE_RST;
      pincfg_r   <= apr_pkg::PINCFG_RST;
      irq_en_r   <= apr_pkg::IRQ_RST;
    end else if (wr_fire) begin
      case (aw_addr_r)
        apr_pkg::ADDR_ROUTE1: route_r[0] <= route_mrg[0];
        apr_pkg::ADDR_ROUTE2: route_r[1] <= route_mrg[1];
        apr_pkg::ADDR_PINCFG: begin
          if (w_strb_r[0]) begin
            pincfg_r <= w_data_r[NP-1:0];
          end
        end
        apr_pkg::ADDR_IRQ_EN: begin
          if (w_strb_r[0]) begin
            irq_en_r <= w_data_r[apr_pkg::IRQ_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // read side: answer one cycle after the address is taken
  always_comb begin
    rd_data_c = 32'h0000_0000;
    rd_err_c  = 1'b0;
    case (araddr)
      apr_pkg::ADDR_ROUTE1:   rd_data_c[RW-1:0] = route_r[0];
      apr_pkg::ADDR_ROUTE2:   rd_data_c[RW-1:0] = route_r[1];
      apr_pkg::ADDR_PINCFG:   rd_data_c[NP-1:0] = pincfg_r;
      apr_pkg::ADDR_IRQ_STAT: rd_data_c[apr_pkg::IRQ_W-1:0] = irq_stat_r;
      apr_pkg::ADDR_IRQ_CLR:  rd_data_c = 32'h0000_0000;
      apr_pkg::ADDR_IRQ_EN:   rd_data_c[apr_pkg::IRQ_W-1:0] = irq_en_r;
      apr_pkg::ADDR_PIN_STAT: begin
        rd_data_c[NP-1:0]              = pin_o_r;
        rd_data_c[apr_pkg::PS_SLOW]    = slow_req_r;
        rd_data_c[apr_pkg::PS_PULSE1]  = pulse_act[0];
        rd_data_c[apr_pkg::PS_PULSE2]  = pulse_act[1];
      end
      default:                rd_err_c = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= apr_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_data_c;
      rresp_r   <= rd_err_c ? apr_pkg::RESP_SLVERR : apr_pkg::RESP_OKAY;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // source vector in routing-register order, channel 1 at the high bit;
  // sources arrive already gated by the alert enable register upstream
  genvar ch;
  generate
    for (ch = 0; ch < apr_pkg::NUM_CH; ch++) begin : g_src
      assign src_vec[apr_pkg::OC_MSB-ch] = ch_overcurrent[ch];
      assign src_vec[apr_pkg::UC_MSB-ch] = ch_undercurrent[ch];
      assign src_vec[apr_pkg::OV_MSB-ch] = ch_overvoltage[ch];
      assign src_vec[apr_pkg::UV_MSB-ch] = ch_undervoltage[ch];
      assign src_vec[apr_pkg::OP_MSB-ch] = ch_overpower[ch];
    end
  endgenerate
  assign src_vec[apr_pkg::ACCV_BIT]  = accum_value_full;
  assign src_vec[apr_pkg::ACCC_BIT]  = accum_count_full;
  assign src_vec[apr_pkg::CC_BIT]    = 1'b0;
  assign src_vec[apr_pkg::UNIMP_BIT] = 1'b0;

  // per-pin routing, pulse and pin drivers
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pin
      // pulse only armed while the pin is in alert function
      assign pulse_start[p] = conv_cycle_end && route_r[p][apr_pkg::CC_BIT]
                              && pincfg_r[p];

      apr_pulse #(
        .CYCLES (apr_pkg::CC_PULSE_CYC),
        .CW     (8)
      ) u_pulse (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (pulse_start[p]),
        .active_r (pulse_act[p])
      );

      assign level_nxt[p] = pincfg_r[p]
                            && ((|(route_r[p] & src_vec)) || pulse_act[p]);

      // pin released whenever alert function is off
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_o_r[p]  <= 1'b0;
          pin_oe_r[p] <= 1'b0;
        end else begin
          pin_o_r[p]  <= level_nxt[p];
          pin_oe_r[p] <= pincfg_r[p];
        end
      end
    end
  endgenerate

  // slow input: three flops, a change counts once the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
      slow_r    <= 1'b0;
    end else begin
      slow_s1_r <= first_alert_pin_i;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
      if (slow_s2_r == slow_s3_r) begin
        slow_r <= slow_s3_r;
      end
    end
  end

  // the pin cannot be both alert output and sampling input
  assign slow_req_nxt = !pincfg_r[0] && slow_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_req_r <= 1'b0;
    end else begin
      slow_req_r <= slow_req_nxt;
    end
  end

  // sticky events; a set in the clear cycle wins so no event is lost
  assign irq_ev[apr_pkg::EV_PIN1] = level_nxt[0] && !pin_o_r[0];
  assign irq_ev[apr_pkg::EV_PIN2] = level_nxt[1] && !pin_o_r[1];
  assign irq_ev[apr_pkg::EV_SLOW] = slow_req_nxt && !slow_req_r;
  assign irq_clr = (wr_fire && aw_addr_r == apr_pkg::ADDR_IRQ_CLR && w_strb_r[0])
                   ? w_data_r[apr_pkg::IRQ_W-1:0] : apr_pkg::IRQ_RST;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= apr_pkg::IRQ_RST;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // checker helper: low routing word of the last write
  assign wd_route = w_data_r[RW-1:0] & apr_pkg::ROUTE_MASK;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  op_route_a: assert property (
    pincfg_r[0] && route_r[0][apr_pkg::OP_MSB] && ch_overpower[0] |=> pin_o_r[0])
    else $error("channel 1 overpower did not drive first pin");

  uv_route_a: assert property (
    pincfg_r[0] && route_r[0][apr_pkg::UV_MSB-3] && ch_undervoltage[3] |=> pin_o_r[0])
    else $error("channel 4 undervoltage did not drive first pin");

  accv_route_a: assert property (
    pincfg_r[1] && route_r[1][apr_pkg::ACCV_BIT] && accum_value_full |=> pin_o_r[1])
    else $error("accumulator value alert did not drive second pin");

  accc_route_a: assert property (
    pincfg_r[0] && route_r[0][apr_pkg::ACCC_BIT] && accum_count_full |=> pin_o_r[0])
    else $error("accumulator count alert did not drive first pin");

  cc_pulse_a: assert property (
    pulse_start[0] |-> ##2 pin_o_r[0] [*8])
    else $error("conversion pulse missing on first pin");

  pulse_gate_a: assert property (
    conv_cycle_end && !pincfg_r[0] |=> !pulse_act[0] || $past(pulse_act[0]))
    else $error("pulse started while pin not in alert function");

  slow_block_a: assert property (
    pincfg_r[0] |=> first_alert_pin_oe ##1 !slow_sample_req)
    else $error("slow input active while pin is alert output");

  bit0_zero_a: assert property (
    !route_r[0][apr_pkg::UNIMP_BIT] && !route_r[1][apr_pkg::UNIMP_BIT])
    else $error("unimplemented routing bit set");

  route2_wr_a: assert property (
    wr_fire && aw_addr_r == apr_pkg::ADDR_ROUTE2 && (&w_strb_r)
    |=> route_r[1] == $past(wd_route))
    else $error("second routing register not written");

  fn2_off_a: assert property (
    !pincfg_r[1] |=> !second_alert_pin_o && !second_alert_pin_oe)
    else $error("second pin driven outside alert function");

  oc_route_a: assert property (
    pincfg_r[1] && route_r[1][apr_pkg::OC_MSB-3] && ch_overcurrent[3] |=> pin_o_r[1])
    else $error("channel 4 overcurrent did not drive second pin");

  uc_route_a: assert property (
    pincfg_r[1] && route_r[1][apr_pkg::UC_MSB] && ch_undercurrent[0] |=> pin_o_r[1])
    else $error("channel 1 undercurrent did not drive second pin");

  reset_clear_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> route_r[0] == apr_pkg::ROUTE_RST && route_r[1] == apr_pkg::ROUTE_RST)
    else $error("routing registers not cleared by reset");

  cc2_pulse_a: assert property (
    pulse_start[1] |-> ##2 pin_o_r[1] [*8])
    else $error("conversion pulse missing on second pin");

  pin1_pulse_c: cover property (pulse_start[0] ##2 pin_o_r[0]);
  pin2_route_c: cover property (pincfg_r[1] && |(route_r[1] & src_vec) ##1 pin_o_r[1]);
  irq_fire_c:   cover property (!irq_r ##1 irq_r);
  slow_in_c:    cover property (!pincfg_r[0] ##1 slow_req_r);

endmodule // apr_top

// ---- verif/apr_host_model.sv ----
`timescale 1ns/1ps
// far-side host: watches the first pin and can drive its slow input level
module apr_host_model (
  input  wire logic aclk,
  input  wire logic first_alert_pin_o,
  input  wire logic first_alert_pin_oe,
  input  wire logic drive_en,
  input  wire logic drive_val,
  output logic      first_alert_pin_i
);
  logic last_r = 1'h0;

  // remember what the host last drove, so a released line does not look held
  always @(posedge aclk) begin
    if (drive_en) begin
      last_r <= drive_val;
    end
  end

  // device output wins while its enable is high; no pull on this line
  assign first_alert_pin_i = first_alert_pin_oe ? first_alert_pin_o :
                             drive_en ? drive_val : ~last_r;
endmodule // apr_host_model

// ---- verif/test_alert_pin_routing.sv ----
`timescale 1ns/1ps
module test_alert_pin_routing;
  localparam int PULSE_CYC = 5000 / 50;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdv;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [23:0] src = 24'h00_0000;
  logic        cce = 1'h0, slow_en = 1'h0, slow_val = 1'h0, pin_i;
  logic        p1_o, p1_oe, p2_o, p2_oe, slow_req, irq;
  int          n_mismatch = 0, n_compared = 0, cyc = 0;

  always #25 aclk = ~aclk;

  // sources arrive already enabled, so routing alone decides the pin
  apr_top i_apr_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ch_overcurrent({src[20], src[21], src[22], src[23]}),
    .ch_undercurrent({src[16], src[17], src[18], src[19]}),
    .ch_overvoltage({src[12], src[13], src[14], src[15]}),
    .ch_undervoltage({src[8], src[9], src[10], src[11]}),
    .ch_overpower({src[4], src[5], src[6], src[7]}),
    .accum_value_full(src[3]), .accum_count_full(src[2]), .conv_cycle_end(cce),
    .first_alert_pin_i(pin_i), .first_alert_pin_o(p1_o), .first_alert_pin_oe(p1_oe),
    .second_alert_pin_o(p2_o), .second_alert_pin_oe(p2_oe), .slow_sample_req(slow_req),
    .irq(irq));

  apr_host_model i_apr_host_model (
    .aclk(aclk), .first_alert_pin_o(p1_o), .first_alert_pin_oe(p1_oe),
    .drive_en(slow_en), .drive_val(slow_val), .first_alert_pin_i(pin_i));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rdv = rdata;
        resp = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask

  // reset value, read-back and the dead bit of both routing words
  task automatic t_regs;
    logic [7:0] a;
    for (int i = 0; i < 2; i++) begin
      a = i ? apr_pkg::ADDR_ROUTE2 : apr_pkg::ADDR_ROUTE1;
      rd(a);
      chk(rdv, 32'h0000_0000);
      wr(a, 32'hFFFF_FFFF);
      rd(a);
      chk(rdv, 32'h00FF_FFFE);
      wr(a, 32'h0000_0000);
    end
  endtask

  // every routing bit from 2 to 23 alone: others' sources high must not leak through
  task automatic t_route;
    wr(apr_pkg::ADDR_PINCFG, 32'h0000_0003);
    for (int p = 0; p < 2; p++) begin
      for (int b = 2; b < 24; b++) begin
        wr(p ? apr_pkg::ADDR_ROUTE2 : apr_pkg::ADDR_ROUTE1, 32'h0000_0001 << b);
        src <= 24'hFF_FFFC & ~(24'h00_0001 << b);
        repeat (3) @(posedge aclk);
        chk({31'h0, p ? p2_o : p1_o}, 32'h0000_0000);
        src <= 24'h00_0001 << b;
        repeat (3) @(posedge aclk);
        chk({31'h0, p ? p2_o : p1_o}, 32'h0000_0001);
      end
      wr(p ? apr_pkg::ADDR_ROUTE2 : apr_pkg::ADDR_ROUTE1, 32'h0000_0000);
    end
    // sources quiet before the next scenario reconfigures anything
    src <= 24'h00_0000;
  endtask

  // conversion-end pulse length, and no pulse while the pin is not in alert use
  task automatic t_pulse;
    int n;
    for (int p = 0; p < 2; p++) begin
      for (int fn = 0; fn < 2; fn++) begin
        wr(p ? apr_pkg::ADDR_ROUTE2 : apr_pkg::ADDR_ROUTE1, 32'h0000_0002);
        wr(apr_pkg::ADDR_PINCFG, fn ? (32'h0000_0001 << p) : (32'h0000_0002 >> p));
        cce <= 1'h1;
        @(posedge aclk);
        cce <= 1'h0;
        n = 0;
        repeat (150) begin
          @(posedge aclk);
          if ((p ? p2_o : p1_o) === 1'h1) n++;
        end
        chk(32'(n), fn ? 32'(PULSE_CYC) : 32'h0000_0000);
        wr(p ? apr_pkg::ADDR_ROUTE2 : apr_pkg::ADDR_ROUTE1, 32'h0000_0000);
      end
    end
  endtask

  // slow input only outside alert use; second pin silent until enabled
  task automatic t_slow;
    wr(apr_pkg::ADDR_PINCFG, 32'h0000_0000);
    wr(apr_pkg::ADDR_ROUTE1, 32'h0080_0000);
    wr(apr_pkg::ADDR_ROUTE2, 32'h0080_0000);
    src <= 24'h80_0000;
    slow_en <= 1'h1;
    slow_val <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({28'h0, slow_req, p1_oe, p2_oe, p2_o}, 32'h0000_0008);
    slow_en <= 1'h0;
    wr(apr_pkg::ADDR_PINCFG, 32'h0000_0003);
    repeat (8) @(posedge aclk);
    chk({28'h0, slow_req, p1_oe, p2_oe, p2_o}, 32'h0000_0007);
    src <= 24'h00_0000;
    wr(apr_pkg::ADDR_ROUTE1, 32'h0000_0000);
    wr(apr_pkg::ADDR_ROUTE2, 32'h0000_0000);
  endtask

  // refused accesses, then the interrupt enabled and masked
  task automatic t_irq;
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, apr_pkg::RESP_SLVERR});
    wr(apr_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    chk({30'h0, resp}, {30'h0, apr_pkg::RESP_SLVERR});
    wr(apr_pkg::ADDR_ROUTE1, 32'h0000_0080);
    for (int en = 1; en >= 0; en--) begin
      wr(apr_pkg::ADDR_IRQ_EN, 32'(en));
      wr(apr_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
      src <= 24'h00_0080;
      repeat (4) @(posedge aclk);
      chk({31'h0, irq}, 32'(en));
      src <= 24'h00_0000;
      rd(apr_pkg::ADDR_IRQ_STAT);
      chk(rdv & 32'h0000_0001, 32'h0000_0001);
      wr(apr_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0000_0000);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 1230 cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict;
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_route;
    t_pulse;
    t_slow;
    t_irq;
    print_verdict;
  end
endmodule // test_alert_pin_routing
